//--- rtl/idp_port.sv
`timescale 1ns/10ps
`default_nettype none
module idp_port
    import idp_pkg::*;
#(
    parameter logic [ID_UNIQUE_W-1:0] ID_UNIQUE = 55'h0123456789ABCD,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fabric side of the identifier port
    input wire logic port_clk,
    input wire logic port_load,
    input wire logic port_shift,
    input wire logic port_din,
    output logic port_dout,
    output logic port_loaded,
    output logic port_cmd_ready,
    // test access port
    input wire logic jtag_tck,
    input wire logic jtag_tms,
    input wire logic jtag_tdi,
    output logic jtag_tdo,
    output logic jtag_tdo_oe
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pins_s;
    logic pclk_s;
    logic load_s;
    logic shift_s;
    logic din_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;

    // one synchroniser for all pins keeps strobes, data and clocks aligned
    assign pins = {jtag_tdi, jtag_tms, jtag_tck, port_din, port_shift, port_load, port_clk};
    assign {tdi_s, tms_s, tck_s, din_s, shift_s, load_s, pclk_s} = pins_s;

    idp_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(pins),
        .sync_out(pins_s)
    );

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic pclk_d;
    logic tck_d;
    logic pclk_rise;
    logic tck_rise;
    logic tck_fall;
    logic next_pclk_d;
    logic next_tck_d;

    assign pclk_rise = pclk_s && !pclk_d;
    assign tck_rise = tck_s && !tck_d;
    assign tck_fall = !tck_s && tck_d;

    // delays reset low, the idle level of both pins, so no false edge
    // follows reset
    always_comb begin
        next_pclk_d = pclk_s;
        next_tck_d = tck_s;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pclk_d <= 1'b0;
            tck_d <= 1'b0;
        end else begin
            pclk_d <= next_pclk_d;
            tck_d <= next_tck_d;
        end
    end

    // ----------------------------------------------------------------
    // fabric command buffer
    // ----------------------------------------------------------------
    // strobes are sampled only at a port clock rising edge; a shift strobe
    // raised while port_clk is high therefore acts at the next edge
    logic cmd_push;
    logic [CMD_W-1:0] cmd_in;
    logic cmd_valid;
    logic cmd_take;
    logic [CMD_W-1:0] cmd;
    logic jtag_busy;

    // hold cycles with no strobe are not queued at all
    assign cmd_push = pclk_rise && (load_s || shift_s);
    assign cmd_in = {load_s, shift_s, din_s};
    assign cmd_take = !jtag_busy;

    idp_fifo #(
        .W(CMD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(cmd_push),
        .in_ready(port_cmd_ready),
        .in_data(cmd_in),
        .out_valid(cmd_valid),
        .out_ready(cmd_take),
        .out_data(cmd)
    );

    // ----------------------------------------------------------------
    // tap controller
    // ----------------------------------------------------------------
    idp_tap_t tap;
    idp_tap_t next_tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic cfg_en;
    logic bypass;
    logic tdo;
    logic tdo_oe;
    logic [IR_W-1:0] next_ir;
    logic [IR_W-1:0] next_ir_sh;
    logic next_cfg_en;
    logic next_bypass;
    logic next_tdo;
    logic next_tdo_oe;
    logic id_sel;
    // declared early: the tdo path reads it before its own section
    logic [ID_W-1:0] sreg;

    assign id_sel = cfg_en && (ir == IR_ID_READOUT);
    assign jtag_busy = id_sel && (tap == IDP_SH_DR);

    always_comb begin
        next_tap = tap;
        case (tap)
            IDP_TLR: next_tap = tms_s ? IDP_TLR : IDP_RTI;
            IDP_RTI: next_tap = tms_s ? IDP_SEL_DR : IDP_RTI;
            IDP_SEL_DR: next_tap = tms_s ? IDP_SEL_IR : IDP_CAP_DR;
            IDP_CAP_DR: next_tap = tms_s ? IDP_EX1_DR : IDP_SH_DR;
            IDP_SH_DR: next_tap = tms_s ? IDP_EX1_DR : IDP_SH_DR;
            IDP_EX1_DR: next_tap = tms_s ? IDP_UPD_DR : IDP_PAU_DR;
            IDP_PAU_DR: next_tap = tms_s ? IDP_EX2_DR : IDP_PAU_DR;
            IDP_EX2_DR: next_tap = tms_s ? IDP_UPD_DR : IDP_SH_DR;
            IDP_UPD_DR: next_tap = tms_s ? IDP_SEL_DR : IDP_RTI;
            IDP_SEL_IR: next_tap = tms_s ? IDP_TLR : IDP_CAP_IR;
            IDP_CAP_IR: next_tap = tms_s ? IDP_EX1_IR : IDP_SH_IR;
            IDP_SH_IR: next_tap = tms_s ? IDP_EX1_IR : IDP_SH_IR;
            IDP_EX1_IR: next_tap = tms_s ? IDP_UPD_IR : IDP_PAU_IR;
            IDP_PAU_IR: next_tap = tms_s ? IDP_EX2_IR : IDP_PAU_IR;
            IDP_EX2_IR: next_tap = tms_s ? IDP_UPD_IR : IDP_SH_IR;
            IDP_UPD_IR: next_tap = tms_s ? IDP_SEL_DR : IDP_RTI;
            default: next_tap = IDP_TLR;
        endcase
        if (!tck_rise) begin
            next_tap = tap;
        end
    end

    // tms passes the same two flops as tck, so both line up at the edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tap <= IDP_TLR;
        end else begin
            tap <= next_tap;
        end
    end

    // ----------------------------------------------------------------
    // instruction and bypass registers
    // ----------------------------------------------------------------
    always_comb begin
        next_ir = ir;
        next_ir_sh = ir_sh;
        next_cfg_en = cfg_en;
        next_bypass = bypass;
        if (tck_rise) begin
            case (tap)
                IDP_TLR: begin
                    next_ir = IR_BYPASS;
                    next_cfg_en = 1'b0;
                end
                IDP_CAP_IR: next_ir_sh = IR_CAPTURE;
                IDP_SH_IR: next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
                IDP_CAP_DR: next_bypass = 1'b0;
                IDP_SH_DR: next_bypass = tdi_s;
                IDP_UPD_IR: begin
                    next_ir = ir_sh;
                    // readout is only honoured once config access is enabled
                    if (ir_sh == IR_CFG_ENABLE) begin
                        next_cfg_en = 1'b1;
                    end else if (ir_sh == IR_CFG_DISABLE) begin
                        next_cfg_en = 1'b0;
                    end
                end
                default: next_cfg_en = cfg_en;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ir <= IR_BYPASS;
            ir_sh <= '0;
            cfg_en <= 1'b0;
            bypass <= 1'b0;
        end else begin
            ir <= next_ir;
            ir_sh <= next_ir_sh;
            cfg_en <= next_cfg_en;
            bypass <= next_bypass;
        end
    end

    // ----------------------------------------------------------------
    // test data output
    // ----------------------------------------------------------------
    // tdo changes on the falling tck edge, as the test port expects
    always_comb begin
        next_tdo = tdo;
        next_tdo_oe = tdo_oe;
        if (tck_fall) begin
            next_tdo_oe = (tap == IDP_SH_DR) || (tap == IDP_SH_IR);
            if (tap == IDP_SH_IR) begin
                next_tdo = ir_sh[0];
            end else if (tap == IDP_SH_DR && id_sel) begin
                next_tdo = sreg[ID_MSB];
            end else if (tap == IDP_SH_DR) begin
                next_tdo = bypass;
            end else begin
                next_tdo = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= next_tdo;
            tdo_oe <= next_tdo_oe;
        end
    end

    assign jtag_tdo = tdo;
    assign jtag_tdo_oe = tdo_oe;

    // ----------------------------------------------------------------
    // identifier shift register
    // ----------------------------------------------------------------
    logic [ID_W-1:0] id_value;
    logic [ID_W-1:0] next_sreg;
    logic loaded;
    logic next_loaded;

    assign id_value = {ID_TOP, ID_UNIQUE};

    // readout and fabric commands never act in one cycle: commands wait
    // in the fifo while the readout owns the register
    always_comb begin
        next_sreg = sreg;
        next_loaded = loaded;
        if (jtag_busy) begin
            // test port shifting: the rest of the id, then bits fed in on tdi
            if (tck_rise && !tms_s) begin
                next_sreg = {sreg[ID_W-2:0], tdi_s};
            end
        end else if (cmd_valid && cmd[CMD_LOAD]) begin
            // load overrides shift; bit 56 then reads 1
            next_sreg = id_value;
            next_loaded = 1'b1;
        end else if (cmd_valid && cmd[CMD_SHIFT]) begin
            // looping dout back to din recirculates with period 57
            next_sreg = {sreg[ID_W-2:0], cmd[CMD_DIN]};
        end
    end

    // contents reset to zero but are flagged invalid until the first load
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sreg <= '0;
            loaded <= 1'b0;
        end else begin
            sreg <= next_sreg;
            loaded <= next_loaded;
        end
    end

    // ----------------------------------------------------------------
    // fabric outputs
    // ----------------------------------------------------------------
    assign port_dout = sreg[ID_MSB];
    assign port_loaded = loaded;

endmodule
`default_nettype wire

//--- rtl/idp_pkg.sv
// Summary of operation
// - 57-bit identifier, top bits 1 then 0
// - load strobe parallel-loads all 57 bits
// - after load, output shows bit 56 (1)
// - load wins over simultaneous shift
// - shift moves toward output, input into bit 0
// - serial output always follows bit 56
// - no strobe: register and output hold, except during a test port readout in Shift-DR
// - loopback repeats identifier every 57 bits
// - readout shows bit 56 entering Shift-DR
// - Shift-DR shifts remaining bits out on TDO
package idp_pkg;

    // ----------------------------------------------------------------
    // identifier
    // ----------------------------------------------------------------
    localparam int ID_W = 57;
    localparam int ID_MSB = 56;
    localparam int ID_UNIQUE_W = 55;
    localparam logic [1:0] ID_TOP = 2'h2;

    // ----------------------------------------------------------------
    // command buffer and synchroniser
    // ----------------------------------------------------------------
    localparam int CMD_W = 3;
    localparam int CMD_LOAD = 2;
    localparam int CMD_SHIFT = 1;
    localparam int CMD_DIN = 0;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_W = 7;

    // ----------------------------------------------------------------
    // test port instructions (codes are arbitrary)
    // ----------------------------------------------------------------
    localparam int IR_W = 6;
    localparam logic [IR_W-1:0] IR_CFG_ENABLE = 6'h10;
    localparam logic [IR_W-1:0] IR_ID_READOUT = 6'h31;
    localparam logic [IR_W-1:0] IR_CFG_DISABLE = 6'h16;
    localparam logic [IR_W-1:0] IR_BYPASS = 6'h3F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;

    typedef enum logic [15:0] {
        IDP_TLR = 16'h0001,
        IDP_RTI = 16'h0002,
        IDP_SEL_DR = 16'h0004,
        IDP_CAP_DR = 16'h0008,
        IDP_SH_DR = 16'h0010,
        IDP_EX1_DR = 16'h0020,
        IDP_PAU_DR = 16'h0040,
        IDP_EX2_DR = 16'h0080,
        IDP_UPD_DR = 16'h0100,
        IDP_SEL_IR = 16'h0200,
        IDP_CAP_IR = 16'h0400,
        IDP_SH_IR = 16'h0800,
        IDP_EX1_IR = 16'h1000,
        IDP_PAU_IR = 16'h2000,
        IDP_EX2_IR = 16'h4000,
        IDP_UPD_IR = 16'h8000
    } idp_tap_t;

endpackage

//--- rtl/idp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module idp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // asynchronous levels in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // stage1 feeds only sync_out; nothing else may look at it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule
`default_nettype wire

//--- rtl/idp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module idp_fifo #(
    parameter int W = 3,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic push;
    logic pop;

    assign in_ready = (wptr - rptr) != (AW+1)'(DEPTH);
    assign out_valid = wptr != rptr;
    assign out_data = mem[rptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wptr = push ? wptr + (AW+1)'(1) : wptr;
        next_rptr = pop ? rptr + (AW+1)'(1) : rptr;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    // storage has no reset; only slots from rptr up to wptr are ever used
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

endmodule
`default_nettype wire

//--- tb/idp_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module idp_port_asserts
    import idp_pkg::*;
#(
    parameter logic [ID_UNIQUE_W-1:0] ID_UNIQUE = 55'h0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fabric port
    input wire logic port_clk,
    input wire logic port_load,
    input wire logic port_shift,
    input wire logic port_din,
    input wire logic port_dout,
    input wire logic port_loaded,
    // test port
    input wire logic jtag_tdo_oe
);
    // ----------------------------------------------------------------
    // pin-level mirror of the shift register
    // ----------------------------------------------------------------
    // a readout must turn the register a whole lap, or the mirror desyncs
    logic [ID_W-1:0] mirror;
    logic [ID_W-1:0] next_mirror;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic clk_prev;
    always_comb begin
        next_mirror = mirror;
        next_quiet = (quiet == 4'h8) ? quiet : quiet + 4'h1;
        if (port_clk && (port_load || port_shift)) begin
            next_quiet = 4'h0;
        end
        if (port_clk && !clk_prev) begin
            if (port_load) begin
                next_mirror = {ID_TOP, ID_UNIQUE};
            end else if (port_shift) begin
                next_mirror = {mirror[ID_MSB-1:0], port_din};
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            quiet <= 4'h8;
            clk_prev <= 1'b1;
            mirror <= '0;
        end else begin
            quiet <= next_quiet;
            clk_prev <= port_clk;
            mirror <= next_mirror;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    dout_quiet_a: assert property ($changed(port_dout) |-> quiet < 4'h8 || jtag_tdo_oe)
        else $error("serial output moved without a command");
    idle_edge_a: assert property ($rose(port_clk) && !port_load && !port_shift &&
        quiet == 4'h8 && !jtag_tdo_oe |=> $stable(port_dout) [*8])
        else $error("serial output moved on a clock edge without strobes");
    load_one_a: assert property ($rose(port_clk) && port_load && !port_shift &&
        !jtag_tdo_oe |-> ##[2:8] (port_dout && port_loaded))
        else $error("load did not present a one");
    load_wins_a: assert property ($rose(port_clk) && port_load && port_shift &&
        !jtag_tdo_oe |-> ##[2:8] port_dout)
        else $error("load with shift did not present a one");
    mirror_match_a: assert property (port_loaded && quiet == 4'h8 && !jtag_tdo_oe
        |-> port_dout == mirror[ID_MSB])
        else $error("serial output differs from the expected register top bit");
    loaded_cause_a: assert property ($rose(port_loaded) |-> quiet < 4'h8)
        else $error("loaded flag rose without a command");
    loaded_dout_a: assert property ($rose(port_loaded) |-> port_dout)
        else $error("loaded flag rose with serial output low");
    loaded_keep_a: assert property (port_loaded |=> port_loaded)
        else $error("loaded flag dropped outside reset");
endmodule
`default_nettype wire

//--- tb/idp_fabric_model.sv
`timescale 1ns/10ps
`default_nettype none
module idp_fabric_model (
    // clock
    input wire logic sys_clk,
    // far side of the identifier port
    input wire logic port_dout,
    output logic port_clk,
    output logic port_load,
    output logic port_shift,
    output logic port_din
);
    // ----------------------------------------------------------------
    // one port clock cycle, each phase four system cycles long
    // ----------------------------------------------------------------
    initial begin
        port_clk = 1'b0;
        port_load = 1'b0;
        port_shift = 1'b0;
        port_din = 1'b0;
    end
    task automatic op(input logic ld, input logic sh, input logic d, input logic loop);
        @(negedge sys_clk);
        port_load = ld;
        port_shift = sh;
        port_din = loop ? port_dout : d;
        repeat (4) @(negedge sys_clk);
        port_clk = 1'b1;
        repeat (4) @(negedge sys_clk);
        port_clk = 1'b0;
        repeat (4) @(negedge sys_clk);
        port_load = 1'b0;
        port_shift = 1'b0;
        // released data line must not keep its last value
        port_din = ~port_din;
    endtask
endmodule
`default_nettype wire

//--- tb/idp_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module idp_port_tb
    import idp_pkg::*;
;
    localparam logic [ID_UNIQUE_W-1:0] UNIQ = 55'h2A5A1234C3F0E1;
    localparam logic [ID_W-1:0] ID = {ID_TOP, UNIQ};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    // test port idle until the readout scenario
    logic jtag_tck = 1'b0;
    logic jtag_tms = 1'b0;
    logic jtag_tdi = 1'b0;
    logic port_clk, port_load, port_shift, port_din, port_dout, port_loaded;
    logic port_cmd_ready, jtag_tdo, jtag_tdo_oe;
    logic [ID_W-1:0] shadow;
    int n_mismatch = 0;
    int compares = 0;
    always #5 sys_clk = ~sys_clk;
    idp_port #(.ID_UNIQUE(UNIQ)) idp_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .port_clk(port_clk), .port_load(port_load), .port_shift(port_shift),
        .port_din(port_din), .port_dout(port_dout), .port_loaded(port_loaded),
        .port_cmd_ready(port_cmd_ready), .jtag_tck(jtag_tck), .jtag_tms(jtag_tms),
        .jtag_tdi(jtag_tdi), .jtag_tdo(jtag_tdo), .jtag_tdo_oe(jtag_tdo_oe));
    idp_fabric_model idp_fabric_model_inst (.sys_clk(sys_clk), .port_dout(port_dout),
        .port_clk(port_clk), .port_load(port_load), .port_shift(port_shift),
        .port_din(port_din));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic load_ex(input logic with_shift);
        idp_fabric_model_inst.op(1'b1, with_shift, 1'b0, 1'b0);
        shadow = ID;
        chk("dout after load", 1'b1, port_dout);
    endtask
    task automatic shift_ex(input logic d, input logic lp);
        idp_fabric_model_inst.op(1'b0, 1'b1, d, lp);
        shadow = {shadow[ID_MSB-1:0], lp ? shadow[ID_MSB] : d};
        chk("dout after shift", shadow[ID_MSB], port_dout);
    endtask
    // one tck cycle, each phase four system cycles; tdo settled on return
    task automatic jtick(input logic ms, input logic di);
        @(negedge sys_clk);
        jtag_tms = ms;
        jtag_tdi = di;
        repeat (4) @(negedge sys_clk);
        jtag_tck = 1'b1;
        repeat (4) @(negedge sys_clk);
        jtag_tck = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    // from run-test-idle, load an instruction lsb first, back to idle
    task automatic jir(input logic [IR_W-1:0] code);
        jtick(1'b1, 1'b0);
        jtick(1'b1, 1'b0);
        jtick(1'b0, 1'b0);
        jtick(1'b0, 1'b0);
        for (int b = 0; b < IR_W; b++) begin
            jtick(b == IR_W - 1, code[b]);
        end
        jtick(1'b1, 1'b0);
        jtick(1'b0, 1'b0);
    endtask
    // data scan; tdo looped to tdi for a whole lap keeps the register intact
    task automatic jread(input logic sel);
        jtick(1'b1, 1'b0);
        jtick(1'b0, 1'b0);
        jtick(1'b0, 1'b0);
        chk("tdo enable in shift", 1'b1, jtag_tdo_oe);
        chk("tdo first bit", sel ? shadow[ID_MSB] : 1'b0, jtag_tdo);
        for (int k = 0; sel && k < ID_W; k++) begin
            jtick(1'b0, jtag_tdo);
            chk("tdo bit", shadow[(ID_MSB - 1 - k + ID_W) % ID_W], jtag_tdo);
        end
        jtick(1'b1, 1'b0);
        jtick(1'b1, 1'b0);
        jtick(1'b0, 1'b0);
        chk("tdo enable after shift", 1'b0, jtag_tdo_oe);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_load();
        chk("loaded before load", 1'b0, port_loaded);
        chk("cmd ready when empty", 1'b1, port_cmd_ready);
        load_ex(1'b0);
        chk("loaded after load", 1'b1, port_loaded);
    endtask
    task automatic t_shift_all();
        load_ex(1'b0);
        for (int k = 1; k <= 60; k++) begin
            shift_ex(k[0], 1'b0);
        end
    endtask
    task automatic t_both();
        load_ex(1'b0);
        shift_ex(1'b1, 1'b0);
        load_ex(1'b1);
        shift_ex(1'b0, 1'b0);
    endtask
    task automatic t_hold();
        load_ex(1'b0);
        shift_ex(1'b1, 1'b0);
        for (int k = 0; k < 3; k++) begin
            idp_fabric_model_inst.op(1'b0, 1'b0, k[0], 1'b0);
            chk("dout while idle", shadow[ID_MSB], port_dout);
        end
        shift_ex(1'b1, 1'b0);
    endtask
    task automatic t_loop();
        load_ex(1'b0);
        for (int k = 1; k <= 2 * ID_W; k++) begin
            shift_ex(1'b0, 1'b1);
            if (k % ID_W == 0) begin
                chk("loop period", ID[ID_MSB], port_dout);
            end
        end
    endtask
    task automatic t_rerst();
        do_reset();
        chk("loaded after reset", 1'b0, port_loaded);
        load_ex(1'b0);
        shift_ex(1'b0, 1'b0);
    endtask
    task automatic t_jtag();
        load_ex(1'b0);
        jtick(1'b0, 1'b0);
        jir(IR_ID_READOUT);
        jread(1'b0);
        jir(IR_CFG_ENABLE);
        jir(IR_ID_READOUT);
        jread(1'b1);
        shift_ex(1'b1, 1'b0);
        shift_ex(1'b0, 1'b0);
        jread(1'b1);
        jir(IR_CFG_DISABLE);
        jir(IR_ID_READOUT);
        jread(1'b0);
        shift_ex(1'b1, 1'b0);
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        shadow = '0;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_load();
        t_shift_all();
        t_both();
        t_hold();
        t_loop();
        t_rerst();
        t_jtag();
        end_of_test();
    end
endmodule
bind idp_port idp_port_asserts #(.ID_UNIQUE(ID_UNIQUE)) idp_port_asserts_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .port_clk(port_clk), .port_load(port_load),
    .port_shift(port_shift), .port_din(port_din), .port_dout(port_dout),
    .port_loaded(port_loaded), .jtag_tdo_oe(jtag_tdo_oe));
`default_nettype wire
